// File: verilog/wdcfg_pkg.sv
`default_nettype none
// ==========================================
// Constants of the watchdog and start-up block
package wdcfg_pkg;
  // ==========================================
  // Clock and widths
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned PS_SEL_W      = 4;
  localparam int unsigned PS_CNT_W      = 15;
  localparam int unsigned BASE_CNT_W    = 32;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam int unsigned SYNC_COUNT    = 2;
  localparam int unsigned SYNC_PIN      = 0;
  localparam int unsigned SYNC_OSC      = 1;

  // ==========================================
  // Register offsets
  localparam logic [7:0] ADDR_WDT_CFG   = 8'h00;
  localparam logic [7:0] ADDR_PIN_CFG   = 8'h04;
  localparam logic [7:0] ADDR_WDT_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_POWER_CFG = 8'h10;

  // ==========================================
  // Field positions
  localparam int unsigned WDT_FORCE_BIT  = 0;
  localparam int unsigned WDT_PS_LSB     = 1;
  localparam int unsigned PIN_SEL_BIT    = 7;
  localparam int unsigned FAST_START_BIT = 3;
  localparam int unsigned CTRL_SWEN_BIT  = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned POWER_UP_DELAY_TIMER_EN_BIT    = 0;
  localparam int unsigned BOR_EN_BIT     = 1;
  localparam int unsigned ST_RUN_BIT     = 0;
  localparam int unsigned ST_CLK_BIT     = 1;
  localparam int unsigned ST_PIN_BIT     = 2;
  localparam int unsigned ST_OSC_BIT     = 3;

  // ==========================================
  // Implemented masks and reset values
  localparam logic [7:0] WDT_CFG_MASK     = 8'h1F;
  localparam logic [7:0] PIN_CFG_MASK     = 8'h88;
  localparam logic [7:0] CTRL_MASK        = 8'h01;
  localparam logic [7:0] POWER_CFG_MASK   = 8'h03;
  localparam logic [7:0] WDT_CFG_ERASED   = 8'h1F;
  localparam logic [7:0] PIN_CFG_ERASED   = 8'h88;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] POWER_CFG_RESET  = 8'h00;

  // ==========================================
  // Clock gate states
  typedef enum logic [0:0] {
    CLK_WAIT,
    CLK_RUN
  } wdcfg_clk_state_t;
endpackage
`default_nettype wire

// File: verilog/wdcfg_postscale.sv
`timescale 1ns/10ps
`default_nettype none
module wdcfg_postscale
  import wdcfg_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          ce_i,
  // Control
  input  wire logic                          run_i,
  input  wire logic                          clear_i,
  input  wire logic                          base_tick_i,
  input  wire logic [wdcfg_pkg::PS_SEL_W-1:0] select_i,
  // Expiry
  output logic                               expire_o
);
  import wdcfg_pkg::*;

  logic [PS_CNT_W-1:0] count_reg;
  logic [PS_CNT_W-1:0] count_next;
  logic                expire_next;
  wire  [PS_CNT_W-1:0] terminal;
  wire                 at_end;

  // ==========================================
  // Ratio of two to the select value
  assign terminal    = PS_CNT_W'((32'd1 << select_i) - 32'd1);
  assign at_end      = base_tick_i && (count_reg == terminal);
  assign count_next  = (!run_i || clear_i || at_end) ? '0 :
                       (base_tick_i ? count_reg + 1'b1 : count_reg);
  assign expire_next = run_i && !clear_i && at_end;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      count_reg <= '0;
      expire_o  <= 1'b0;
    end else if (ce_i) begin
      count_reg <= count_next;
      expire_o  <= expire_next;
    end
  end
endmodule
`default_nettype wire

// File: verilog/wdcfg_top.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module wdcfg_top
  import wdcfg_pkg::*;
#(
  parameter int unsigned WDT_BASE_NS = 4000000
) (
  // Clock, reset, enable
  input  wire logic                        sys_clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        ce_i,
  // APB slave
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [wdcfg_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [wdcfg_pkg::DATA_W-1:0] pwdata_i,
  output logic [wdcfg_pkg::DATA_W-1:0]     prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  // Pin and oscillator
  input  wire logic                        shared_input_pin_i,
  input  wire logic                        osc_stable_i,
  input  wire logic                        sleep_i,
  // Device outputs
  output logic                             external_reset_o,
  output logic                             gpio_in_o,
  output logic                             cpu_clk_en_o,
  output logic                             watchdog_run_o,
  output logic                             watchdog_reset_o,
  output logic                             watchdog_wake_o,
  output logic                             power_up_timer_en_o,
  output logic                             brownout_en_o
);
  import wdcfg_pkg::*;

  localparam int unsigned BASE_CYC =
    (WDT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [BASE_CNT_W-1:0] BASE_LAST =
    BASE_CNT_W'((BASE_CYC > 1) ? BASE_CYC - 1 : 0);

  // ==========================================
  // Registers
  logic [BYTE_W-1:0]     wdt_cfg_reg;
  logic [BYTE_W-1:0]     pin_cfg_reg;
  logic [BYTE_W-1:0]     ctrl_reg;
  logic [BYTE_W-1:0]     power_cfg_reg;
  logic [DATA_W-1:0]     prdata_reg;
  logic                  rd_valid_reg;
  logic                  clear_reg;
  logic [BASE_CNT_W-1:0] base_cnt_reg;
  logic                  base_tick_reg;
  logic                  expire;
  logic                  reset_out_reg;
  logic                  wake_out_reg;
  logic                  ext_reset_reg;
  logic                  gpio_reg;
  wdcfg_clk_state_t      clk_state_reg;
  wdcfg_clk_state_t      clk_state_next;
  logic [SYNC_STAGES-1:0] sync_reg [SYNC_COUNT];
  logic [SYNC_COUNT-1:0]  level_reg;

  // ==========================================
  // Bus decode
  wire                sel_wdt_cfg   = (paddr_i == ADDR_WDT_CFG);
  wire                sel_pin_cfg   = (paddr_i == ADDR_PIN_CFG);
  wire                sel_ctrl      = (paddr_i == ADDR_WDT_CTRL);
  wire                sel_status    = (paddr_i == ADDR_STATUS);
  wire                sel_power     = (paddr_i == ADDR_POWER_CFG);
  wire                mapped        = sel_wdt_cfg | sel_pin_cfg | sel_ctrl |
                                      sel_status | sel_power;
  wire                access_done   = psel_i && penable_i && pready_o;
  wire                wr_en         = access_done && pwrite_i && mapped;
  wire [BYTE_W-1:0]   wr_byte       = pwdata_i[BYTE_W-1:0];
  wire [BYTE_W-1:0]   status_byte;
  wire [BYTE_W-1:0]   rd_byte;
  wire [DATA_W-1:0]   rd_word;

  assign pready_o  = ce_i && rd_valid_reg;
  assign pslverr_o = pready_o && psel_i && penable_i && !mapped;
  assign prdata_o  = prdata_reg;

  // ==========================================
  // Read selection
  assign status_byte = BYTE_W'({level_reg[SYNC_OSC], level_reg[SYNC_PIN],
                               cpu_clk_en_o, watchdog_run_o});
  assign rd_byte = sel_wdt_cfg ? (wdt_cfg_reg & WDT_CFG_MASK) :
                   sel_pin_cfg ? (pin_cfg_reg & PIN_CFG_MASK) :
                   sel_ctrl    ? (ctrl_reg & CTRL_MASK) :
                   sel_status  ? status_byte :
                   sel_power   ? (power_cfg_reg & POWER_CFG_MASK) :
                   '0;
  assign rd_word = DATA_W'(rd_byte);

  // ==========================================
  // Bus handshake
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_valid_reg <= 1'b0;
      prdata_reg   <= '0;
    end else if (ce_i) begin
      rd_valid_reg <= psel_i && !access_done;
      if (psel_i && !access_done) begin
        prdata_reg <= rd_word;
      end
    end
  end

  // ==========================================
  // Configuration programming
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wdt_cfg_reg   <= WDT_CFG_ERASED;
      pin_cfg_reg   <= PIN_CFG_ERASED;
      ctrl_reg      <= CTRL_RESET;
      power_cfg_reg <= POWER_CFG_RESET;
      clear_reg     <= 1'b0;
    end else if (ce_i) begin
      clear_reg <= wr_en && sel_ctrl && wr_byte[CTRL_CLEAR_BIT];
      if (wr_en && sel_wdt_cfg) begin
        wdt_cfg_reg <= wr_byte & WDT_CFG_MASK;
      end
      if (wr_en && sel_pin_cfg) begin
        pin_cfg_reg <= wr_byte & PIN_CFG_MASK;
      end
      if (wr_en && sel_ctrl) begin
        ctrl_reg <= wr_byte & CTRL_MASK;
      end
      if (wr_en && sel_power) begin
        power_cfg_reg <= wr_byte & POWER_CFG_MASK;
      end
    end
  end

  // Each enable drives only its own output
  assign power_up_timer_en_o = power_cfg_reg[POWER_UP_DELAY_TIMER_EN_BIT];
  assign brownout_en_o       = power_cfg_reg[BOR_EN_BIT];

  // ==========================================
  // Input synchronisers
  wire [SYNC_COUNT-1:0] raw_in = {osc_stable_i, shared_input_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_COUNT; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          sync_reg[gi]  <= '0;
          level_reg[gi] <= 1'b0;
        end else if (ce_i) begin
          sync_reg[gi] <= {sync_reg[gi][SYNC_STAGES-2:0], raw_in[gi]};
          if (sync_reg[gi][SYNC_STAGES-1] == sync_reg[gi][SYNC_STAGES-2]) begin
            level_reg[gi] <= sync_reg[gi][SYNC_STAGES-2];
          end
        end
      end
    end
  endgenerate

  // ==========================================
  // Shared pin function
  wire pin_is_reset = pin_cfg_reg[PIN_SEL_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ext_reset_reg <= 1'b0;
      gpio_reg      <= 1'b0;
    end else if (ce_i) begin
      ext_reset_reg <= pin_is_reset && !level_reg[SYNC_PIN];
      gpio_reg      <= !pin_is_reset && level_reg[SYNC_PIN];
    end
  end

  assign external_reset_o = ext_reset_reg;
  assign gpio_in_o        = gpio_reg;

  // ==========================================
  // CPU clock gate
  wire fast_start = pin_cfg_reg[FAST_START_BIT];
  wire clk_ok     = level_reg[SYNC_OSC];

  always_comb begin
    clk_state_next = clk_state_reg;
    case (clk_state_reg)
      CLK_WAIT: begin
        if (clk_ok) begin
          clk_state_next = CLK_RUN;
        end
      end
      CLK_RUN: begin
        clk_state_next = CLK_RUN;
      end
      default: begin
        clk_state_next = CLK_WAIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      clk_state_reg <= CLK_WAIT;
    end else if (ce_i) begin
      clk_state_reg <= clk_state_next;
    end
  end

  // Held off in wait until stable, unless fast start
  assign cpu_clk_en_o = (clk_state_reg == CLK_RUN) || fast_start;

  // ==========================================
  // Watchdog timing
  wire wdt_run = wdt_cfg_reg[WDT_FORCE_BIT] || ctrl_reg[CTRL_SWEN_BIT];
  wire base_end = (base_cnt_reg == BASE_LAST);

  assign watchdog_run_o = wdt_run;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      base_cnt_reg  <= '0;
      base_tick_reg <= 1'b0;
    end else if (ce_i) begin
      if (!wdt_run || clear_reg || base_end) begin
        base_cnt_reg <= '0;
      end else begin
        base_cnt_reg <= base_cnt_reg + 1'b1;
      end
      base_tick_reg <= wdt_run && !clear_reg && base_end;
    end
  end

  wdcfg_postscale u_postscale (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .run_i       (wdt_run),
    .clear_i     (clear_reg),
    .base_tick_i (base_tick_reg),
    .select_i    (wdt_cfg_reg[WDT_PS_LSB +: PS_SEL_W]),
    .expire_o    (expire)
  );

  // ==========================================
  // Expiry action
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reset_out_reg <= 1'b0;
      wake_out_reg  <= 1'b0;
    end else if (ce_i) begin
      reset_out_reg <= expire && !sleep_i;
      wake_out_reg  <= expire && sleep_i;
    end
  end

  assign watchdog_reset_o = reset_out_reg;
  assign watchdog_wake_o  = wake_out_reg;
endmodule
`default_nettype wire

// File: dv/wdcfg_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module wdcfg_monitor
  import wdcfg_pkg::*;
#(
  parameter int unsigned WDT_BASE_NS = 4000000
) (
  // Clock and bus
  input wire logic                          sys_clk_i,
  input wire logic                          reset_i,
  input wire logic                          ce_i,
  input wire logic                          psel_i,
  input wire logic                          penable_i,
  input wire logic                          pwrite_i,
  input wire logic [wdcfg_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [wdcfg_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [wdcfg_pkg::DATA_W-1:0] prdata_o,
  input wire logic                          pready_o,
  input wire logic                          pslverr_o,
  // Pin and oscillator
  input wire logic                          shared_input_pin_i,
  input wire logic                          osc_stable_i,
  input wire logic                          sleep_i,
  // Device outputs
  input wire logic                          external_reset_o,
  input wire logic                          gpio_in_o,
  input wire logic                          cpu_clk_en_o,
  input wire logic                          watchdog_run_o,
  input wire logic                          watchdog_reset_o,
  input wire logic                          watchdog_wake_o,
  input wire logic                          power_up_timer_en_o,
  input wire logic                          brownout_en_o
);
  import wdcfg_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // Completed transfers
  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_acc = psel_i && penable_i && pready_o && !pwrite_i;
  sequence s_wr(logic [7:0] a); wr_acc && paddr_i == a; endsequence
  // ==========================================
  // Properties
  property p_force; s_wr(ADDR_WDT_CFG) ##0 pwdata_i[0] |=> watchdog_run_o; endproperty
  property p_gpio_off; s_wr(ADDR_PIN_CFG) ##0 pwdata_i[7] |-> ##2 !gpio_in_o; endproperty
  property p_rst_off; s_wr(ADDR_PIN_CFG) ##0 !pwdata_i[7] |-> ##2 !external_reset_o; endproperty
  property p_fast; s_wr(ADDR_PIN_CFG) ##0 pwdata_i[3] |=> cpu_clk_en_o; endproperty
  property p_held; (osc_stable_i && ce_i) [*5] |=> cpu_clk_en_o; endproperty
  property p_rd_mask; rd_acc && paddr_i == ADDR_WDT_CFG |-> prdata_o[31:5] == 27'h0; endproperty
  property p_pwr; s_wr(ADDR_POWER_CFG) |=> power_up_timer_en_o == $past(pwdata_i[0])
    && brownout_en_o == $past(pwdata_i[1]); endproperty
  property p_erase; $fell(reset_i) |-> watchdog_run_o && cpu_clk_en_o; endproperty
  property p_pulse; watchdog_reset_o && ce_i |=> !watchdog_reset_o; endproperty
  property p_excl; !(watchdog_reset_o && watchdog_wake_o); endproperty
  a_force: assert property (p_force) else $error("watchdog not forced on");
  a_gpio_off: assert property (p_gpio_off) else $error("input path live in reset mode");
  a_rst_off: assert property (p_rst_off) else $error("reset live in input mode");
  a_fast: assert property (p_fast) else $error("clock held in fast start");
  a_held: assert property (p_held) else $error("clock held after stable");
  a_rd_mask: assert property (p_rd_mask) else $error("unused bits not zero");
  a_pwr: assert property (p_pwr) else $error("power enables wrong");
  a_erase: assert property (p_erase) else $error("erased state wrong");
  a_pulse: assert property (p_pulse) else $error("expiry pulse too long");
  a_excl: assert property (p_excl) else $error("reset and wake together");
endmodule
bind wdcfg_top wdcfg_monitor #(.WDT_BASE_NS(WDT_BASE_NS)) u_wdcfg_monitor (
  .sys_clk_i, .reset_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .shared_input_pin_i, .osc_stable_i, .sleep_i,
  .external_reset_o, .gpio_in_o, .cpu_clk_en_o, .watchdog_run_o, .watchdog_reset_o,
  .watchdog_wake_o, .power_up_timer_en_o, .brownout_en_o
);
`default_nettype wire

// File: dv/wdcfg_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module wdcfg_top_tb;
  import wdcfg_pkg::*;
  localparam int BASE_CYC = 5;
  // ==========================================
  // Signals
  logic        sys_clk_i, reset_i, ce_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rq;
  logic        pready_o, pslverr_o, shared_input_pin_i, osc_stable_i, sleep_i, re;
  logic        external_reset_o, gpio_in_o, cpu_clk_en_o, watchdog_run_o;
  logic        watchdog_reset_o, watchdog_wake_o, power_up_timer_en_o, brownout_en_o;
  int          miscompares = 0;
  int          checks = 0;
  int          n;
  wdcfg_top #(.WDT_BASE_NS(BASE_CYC * CLK_PERIOD_NS)) u_wdcfg_top (
    .sys_clk_i, .reset_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .shared_input_pin_i, .osc_stable_i, .sleep_i,
    .external_reset_o, .gpio_in_o, .cpu_clk_en_o, .watchdog_run_o, .watchdog_reset_o,
    .watchdog_wake_o, .power_up_timer_en_o, .brownout_en_o
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================
  // Shared tasks
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      give_verdict();
    end
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rq, exp);
  endtask
  task automatic pins(input logic p, input logic o, input logic s);
    @(posedge sys_clk_i);
    shared_input_pin_i <= p;
    osc_stable_i <= o;
    sleep_i <= s;
    repeat (8) @(negedge sys_clk_i);
  endtask
  task automatic wait_wdt(input logic wk);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while ((wk ? watchdog_wake_o : watchdog_reset_o) !== 1'b1 && n < 400);
    if (n >= 400) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_erased();
    rd_chk("wdt cfg", ADDR_WDT_CFG, 32'h0000001F);
    rd_chk("pin cfg", ADDR_PIN_CFG, 32'h00000088);
    check("run", watchdog_run_o, 32'h1);
    check("cpu clk", cpu_clk_en_o, 32'h1);
  endtask
  task automatic t_unused();
    apb(1'b1, ADDR_WDT_CFG, 32'hFFFFFFFF);
    rd_chk("wdt cfg ones", ADDR_WDT_CFG, 32'h0000001F);
    apb(1'b1, ADDR_PIN_CFG, 32'h00000077);
    rd_chk("pin cfg gaps", ADDR_PIN_CFG, 32'h00000000);
    apb(1'b1, ADDR_PIN_CFG, 32'hFFFFFFFF);
    rd_chk("pin cfg ones", ADDR_PIN_CFG, 32'h00000088);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", re, 32'h1);
  endtask
  task automatic t_pin();
    pins(1'b0, 1'b0, 1'b0);
    check("ext reset", external_reset_o, 32'h1);
    check("gpio", gpio_in_o, 32'h0);
    apb(1'b1, ADDR_PIN_CFG, 32'h00000008);
    pins(1'b1, 1'b0, 1'b0);
    check("ext reset input", external_reset_o, 32'h0);
    check("gpio input", gpio_in_o, 32'h1);
    apb(1'b1, ADDR_PIN_CFG, 32'h00000088);
    pins(1'b1, 1'b0, 1'b0);
    check("gpio reset mode", gpio_in_o, 32'h0);
  endtask
  task automatic t_clk();
    apb(1'b1, ADDR_PIN_CFG, 32'h00000080);
    check("cpu clk held", cpu_clk_en_o, 32'h0);
    pins(1'b1, 1'b1, 1'b0);
    check("cpu clk stable", cpu_clk_en_o, 32'h1);
    rd_chk("status", ADDR_STATUS, 32'h0000000F);
  endtask
  task automatic t_wdt();
    apb(1'b1, ADDR_WDT_CFG, 32'h00000000);
    check("run sw off", watchdog_run_o, 32'h0);
    apb(1'b1, ADDR_WDT_CTRL, 32'h00000001);
    check("run sw on", watchdog_run_o, 32'h1);
    for (int ps = 0; ps < 4; ps++) begin
      apb(1'b1, ADDR_WDT_CFG, {27'h0, 4'(ps), 1'b0});
      wait_wdt(1'b0);
      wait_wdt(1'b0);
      check("period", n, BASE_CYC << ps);
    end
    pins(1'b1, 1'b1, 1'b1);
    wait_wdt(1'b1);
    check("wake in time", n, (BASE_CYC << 3) - 8);
    pins(1'b1, 1'b1, 1'b0);
    apb(1'b1, ADDR_WDT_CTRL, 32'h00000000);
    apb(1'b1, ADDR_WDT_CFG, 32'h00000001);
    check("run forced", watchdog_run_o, 32'h1);
  endtask
  task automatic t_power();
    int v[4] = '{0, 1, 3, 2};
    foreach (v[i]) begin
      apb(1'b1, ADDR_POWER_CFG, v[i]);
      check("power_up_delay_timer", power_up_timer_en_o, v[i] & 1);
      check("bor", brownout_en_o, v[i] >> 1);
    end
  endtask
  initial begin
    {reset_i, ce_i, shared_input_pin_i} = 3'h7;
    {psel_i, penable_i, pwrite_i, osc_stable_i, sleep_i} = 5'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (8) @(negedge sys_clk_i);
    t_erased();
    t_unused();
    t_pin();
    t_clk();
    t_wdt();
    t_power();
    give_verdict();
  end
endmodule
`default_nettype wire
